// >>> testbench.sv
// Self-checking testbench for the touchkey channel data block
`timescale 1ns/100ps
module testbench;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, v, hi;
	logic        reg_wr, near_enable;
	logic        meas_valid = 1'b0;
	logic        cal_tick = 1'b0;
	logic [3:0]  meas_ch = 4'h0;
	logic [3:0]  near_channel;
	logic [12:0] meas_imp = 13'h0000;
	logic [15:0] near_result = 16'hc33c;
	logic [1:0]  near_dither;
	logic [5:0]  chan_delay_sel;
	logic [7:0]  rw [6] = '{8'h90, 8'h92, 8'h93, 8'h96, 8'h97, 8'h98};
	int          err_count = 0;
	int          samples_checked = 0;
	always #25 ref_clk = ~ref_clk;
	tkcda_top dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.meas_valid(meas_valid), .meas_ch(meas_ch), .meas_imp(meas_imp),
		.cal_tick(cal_tick), .near_result(near_result),
		.near_enable(near_enable), .near_channel(near_channel),
		.near_dither(near_dither), .chan_delay_sel(chan_delay_sel));
	tkcda_host h (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task w(input logic [7:0] a, input logic [7:0] d);
		h.wr(a, d);
	endtask
	task r(input logic [7:0] a, input logic [7:0] e);
		h.rd(a, v);
		chk(v, e);
	endtask
	task m(input logic [3:0] c, input logic [12:0] i);
		@(negedge ref_clk);
		meas_ch = c;
		meas_imp = i;
		meas_valid = 1'b1;
		@(negedge ref_clk);
		meas_valid = 1'b0;
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task t_regs;
		foreach (rw[i]) begin
			r(rw[i], 8'h00);
			w(rw[i], 8'ha5 ^ 8'(i));
			r(rw[i], 8'ha5 ^ 8'(i));
		end
		r(8'hb1, 8'hc3);
		w(8'hb0, 8'hff);
		r(8'hb0, 8'h3c);
		r(8'h80, 8'h00);
		w(8'h90, 8'hb4);
		chk({near_channel, near_dither, 1'b0, near_enable}, 16'h00b9);
		$display("t_regs done");
	endtask
	task t_thr;
		w(8'h7c, 8'h01);
		w(8'hde, 8'h34);
		w(8'hdf, 8'h01);
		r(8'hde, 8'h34);
		r(8'hdf, 8'h01);
		w(8'h7c, 8'h02);
		r(8'hde, 8'h00);
		w(8'h7c, 8'h03);
		w(8'hc6, 8'h3f);
		w(8'hc7, 8'hff);
		r(8'hc7, 8'h00);
		@(negedge ref_clk);
		meas_ch = 4'h3;
		#1 chk(chan_delay_sel, 16'h003f);
		w(8'h7c, 8'h04);
		w(8'hc0, 8'h55);
		r(8'hc0, 8'h00);
		$display("t_thr done");
	endtask
	task t_touch;
		w(8'h7c, 8'h01);
		w(8'hc4, 8'h00);
		w(8'hc5, 8'h01);
		m(4'h2, 13'h0100);
		r(8'hb4, 8'h00);
		m(4'h2, 13'h0101);
		m(4'h1, 13'h0050);
		r(8'hb4, 8'h06);
		r(8'hb5, 8'h00);
		w(8'h92, 8'h06);
		w(8'h93, 8'h00);
		for (int k = 0; k < 4; k++) begin
			w(8'h90, 8'(k));
			r(8'h9a, (k == 1) ? 8'h04 : 8'h06);
		end
		w(8'h7c, 8'h04);
		r(8'hc4, 8'h01);
		hi = v;
		h.rd(8'hc5, v);
		chk(h.imp_use({v[4:0], hi}), 16'h010);
		w(8'h7c, 8'h02);
		w(8'hc4, 8'hff);
		w(8'hc5, 8'h01);
		@(negedge ref_clk);
		cal_tick = 1'b1;
		@(negedge ref_clk);
		cal_tick = 1'b0;
		w(8'h7c, 8'h05);
		r(8'hc4, 8'h01);
		r(8'hc2, 8'h00);
		r(8'hb4, 8'h02);
		$display("t_touch done");
	endtask
	task t_frz;
		w(8'h7c, 8'h06);
		for (int c = 0; c < 16; c++) m(4'(c), 13'h0200 + 13'(c * 16));
		m(4'h0, 13'h1fff);
		r(8'hc1, 8'h02);
		r(8'hde, 8'hf0);
		w(8'h7c, 8'h04);
		r(8'hc1, 8'h1f);
		$display("t_frz done");
	endtask
	initial begin
		#(2000 * 50);
		err_count++;
		wrap_up;
	end
	initial begin
		repeat (16) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (3) @(negedge ref_clk);
		t_regs;
		t_thr;
		t_touch;
		t_frz;
		wrap_up;
	end
endmodule // testbench

// >>> tkcda_host.sv
// Host model driving the register port of the touchkey block
`timescale 1ns/100ps
module tkcda_host (
	// Clock
	input  wire logic       ref_clk,
	// Register port
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end
	// Data is inverted after the strobe so a stale byte is never seen
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		#1 d = reg_rdata;
	endtask
	// Usable impedance drops the processing residue
	function automatic logic [8:0] imp_use(input logic [12:0] v);
		return v[12:4];
	endfunction
endmodule // tkcda_host

// >>> tkcda_pkg.sv
// Package with register map, fields and constants of the touchkey data block
package tkcda_pkg;
	localparam int NCH = 16;
	localparam logic [7:0] OFS_DATA_TYPE   = 8'h7c;
	localparam logic [7:0] OFS_KF_CTRL     = 8'h90;
	localparam logic [7:0] OFS_KF_MASK_LO  = 8'h92;
	localparam logic [7:0] OFS_KF_MASK_HI  = 8'h93;
	localparam logic [7:0] OFS_NEAR_CFG    = 8'h96;
	localparam logic [7:0] OFS_NEAR_TOUCH  = 8'h97;
	localparam logic [7:0] OFS_NEAR_DRIFT  = 8'h98;
	localparam logic [7:0] OFS_FILT_LO     = 8'h9a;
	localparam logic [7:0] OFS_FILT_HI     = 8'h9b;
	localparam logic [7:0] OFS_NEAR_RES0   = 8'hb0;
	localparam logic [7:0] OFS_NEAR_RES1   = 8'hb1;
	localparam logic [7:0] OFS_PRESS_LO    = 8'hb4;
	localparam logic [7:0] OFS_PRESS_HI    = 8'hb5;
	localparam logic [7:0] OFS_CH_BASE     = 8'hc0;
	localparam logic [7:0] OFS_CH_LAST     = 8'hdf;
	localparam logic [7:0] RST_BYTE        = 8'h00;
	localparam logic [15:0] RST_WORD       = 16'h0000;
	localparam logic [7:0] DT_TOUCH_THR    = 8'h01;
	localparam logic [7:0] DT_ENV_THR      = 8'h02;
	localparam logic [7:0] DT_DELAY        = 8'h03;
	localparam logic [7:0] DT_RAW          = 8'h04;
	localparam logic [7:0] DT_CAL          = 8'h05;
	localparam logic [7:0] DT_FROZEN       = 8'h06;
	localparam int KF_MODE_LSB = 0;
	localparam int NEAR_EN_BIT = 2;
	localparam int NEAR_CH_LSB = 4;
	localparam int DITH_LSB    = 6;
	localparam int THR_W = 9;
	localparam int DLY_W = 6;
	localparam int IMP_W = 13;
endpackage

// >>> tkcda_props.sv
// Concurrent checks on the ports of the touchkey data block
`timescale 1ns/100ps
module tkcda_props (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        nrst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	// Front end and nearness
	input wire logic        meas_valid,
	input wire logic        cal_tick,
	input wire logic [15:0] near_result,
	input wire logic        near_enable,
	input wire logic [3:0]  near_channel,
	input wire logic [1:0]  near_dither
);
	logic [1:0] up_r;
	logic [7:0] sel_r;
	logic       go;
	logic       wr_ok;
	assign go = up_r == 2'd3;
	assign wr_ok = go && reg_wr;
	// Internal reset lags the pin by two edges, so checks wait for it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			up_r <= 2'd0;
			sel_r <= 8'h00;
		end else begin
			up_r <= go ? up_r : up_r + 2'd1;
			sel_r <= (wr_ok && reg_addr == 8'h7c) ? reg_wdata : sel_r;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	AST_NEAR_EN: assert property (wr_ok && reg_addr == 8'h90 |=>
		near_enable == $past(reg_wdata[2])) else $error("enable bad");
	AST_NEAR_CH: assert property (wr_ok && reg_addr == 8'h90 |=>
		near_channel == $past(reg_wdata[7:4])) else $error("channel bad");
	AST_DITHER: assert property (wr_ok && reg_addr == 8'h96 |=>
		near_dither == $past(reg_wdata[7:6])) else $error("dither bad");
	AST_KF_MASK: assert property (wr_ok && reg_addr == 8'h92 ##1
		reg_addr == 8'h92 |-> reg_rdata == $past(reg_wdata))
		else $error("mask readback bad");
	AST_SEL: assert property (wr_ok && reg_addr == 8'h7c ##1
		reg_addr == 8'h7c |-> reg_rdata == $past(reg_wdata))
		else $error("selector readback bad");
	AST_THR: assert property (wr_ok && sel_r == 8'h01 && reg_addr == 8'hc4
		##1 reg_addr == 8'hc4 |-> reg_rdata == $past(reg_wdata))
		else $error("threshold readback bad");
	AST_NEAR_RES: assert property (go && reg_addr == 8'hb0 |->
		reg_rdata == $past(near_result[7:0])) else $error("result bad");
	AST_IMP_RO: assert property (wr_ok && reg_addr == 8'hc0 &&
		sel_r == 8'h04 && !meas_valid && !cal_tick |=>
		reg_addr != 8'hc0 || $stable(reg_rdata)) else $error("raw written");
endmodule // tkcda_props
bind tkcda_top tkcda_props u_props (.ref_clk(ref_clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .meas_valid(meas_valid), .cal_tick(cal_tick),
	.near_result(near_result), .near_enable(near_enable),
	.near_channel(near_channel), .near_dither(near_dither));

// >>> tkcda_top.sv
// Channel data window, touch decision, key filter and nearness registers
// Behaviour
// - Sixteen two-byte channel slots at 0xc0 plus twice channel, zero reset
// - One data type selector decides what every channel slot shows
// - Selector 1..6: touch thr, drift thr, delay, raw, calibrated, frozen
// - Channel touched when impedance departs reference beyond touch threshold
// - Touch outcomes shown live, one bit per channel, at 0xb4-0xb5
// - Change below drift threshold moves the calibrated reference
// - Per-channel six-bit delay, 0 to 63, about 0.5 pF a step
// - Raw impedance refreshed continuously; falls as capacitance rises
// - Calibrated reference read-only, updated at calibration points
// - Frozen type captures one full impedance set then holds it
// - Measurements turned into a touched flag per channel
// - Key filter caps active group 1 keys, choosing by largest change
// - Filter mode 0 none, 1..3 keep that many largest changes
// - Nearness dithering on one chosen channel, factor 4x to 32x
// - Combined key filter and nearness control at 0x90, read-write
// - Sixteen-bit group 1 mask at 0x92, read-write, zero reset
// - Nearness touch and drift thresholds at 0x97, 0x98, zero reset
// - Nearness results read-only at 0xb0 and 0xb1, zero reset
`timescale 1ns/100ps
module tkcda_top (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                nrst,
	// Register port from the serial host interface
	input  wire logic [7:0]          reg_addr,
	input  wire logic                reg_wr,
	input  wire logic [7:0]          reg_wdata,
	output logic      [7:0]          reg_rdata,
	// Measurement front end, one sample per strobe
	input  wire logic                meas_valid,
	input  wire logic [3:0]          meas_ch,
	input  wire logic [12:0]         meas_imp,
	input  wire logic                cal_tick,
	// Nearness engine results and controls, and the analog delay line select
	input  wire logic [15:0]         near_result,
	output logic                     near_enable,
	output logic      [3:0]          near_channel,
	output logic      [1:0]          near_dither,
	output logic      [5:0]          chan_delay_sel
);
	localparam int IW = tkcda_pkg::IMP_W;
	logic        rst_s1_r;
	logic        rst_n_r;
	logic [7:0]  dtype_r;
	logic [7:0]  kf_ctrl_r;
	logic [15:0] kf_mask_r;
	logic [7:0]  near_cfg_r;
	logic [7:0]  near_touch_r;
	logic [7:0]  near_drift_r;
	logic [15:0] near_res_r;
	logic [15:0] press_r;
	logic [15:0] filt_r;
	logic        frozen_busy_r;
	logic [15:0] frozen_got_r;
	logic [8:0]    tthr_r   [tkcda_pkg::NCH];
	logic [8:0]    ethr_r   [tkcda_pkg::NCH];
	logic [5:0]    dly_r    [tkcda_pkg::NCH];
	logic [IW-1:0] raw_r    [tkcda_pkg::NCH];
	logic [IW-1:0] cal_r    [tkcda_pkg::NCH];
	logic [IW-1:0] frz_r    [tkcda_pkg::NCH];
	logic [IW-1:0] diff_w   [tkcda_pkg::NCH];
	logic [15:0] touch_w;
	logic [15:0] drift_w;

	// Reset released through two flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// Address decode
	wire        in_ch   = reg_addr >= tkcda_pkg::OFS_CH_BASE &&
	                      reg_addr <= tkcda_pkg::OFS_CH_LAST;
	wire [7:0]  ch_off  = reg_addr - tkcda_pkg::OFS_CH_BASE;
	wire [3:0]  ch_idx  = ch_off[4:1];
	wire        ch_hi   = ch_off[0];
	wire        wr_ch   = reg_wr && in_ch;
	wire        sel_t   = dtype_r == tkcda_pkg::DT_TOUCH_THR;
	wire        sel_e   = dtype_r == tkcda_pkg::DT_ENV_THR;
	wire        sel_d   = dtype_r == tkcda_pkg::DT_DELAY;
	wire        frz_sel = dtype_r == tkcda_pkg::DT_FROZEN;
	wire        wr_dt   = reg_wr && reg_addr == tkcda_pkg::OFS_DATA_TYPE;
	// Only the threshold and delay types take slot writes
	wire        wr_tthr = wr_ch && sel_t;
	wire        wr_ethr = wr_ch && sel_e;
	wire        wr_dly  = wr_ch && sel_d && !ch_hi;
	// Host register write strobes
	wire        wr_kfc  = reg_wr &&
	                      reg_addr == tkcda_pkg::OFS_KF_CTRL;
	wire        wr_mlo  = reg_wr &&
	                      reg_addr == tkcda_pkg::OFS_KF_MASK_LO;
	wire        wr_mhi  = reg_wr &&
	                      reg_addr == tkcda_pkg::OFS_KF_MASK_HI;
	wire        wr_ncfg = reg_wr &&
	                      reg_addr == tkcda_pkg::OFS_NEAR_CFG;
	wire        wr_ntch = reg_wr &&
	                      reg_addr == tkcda_pkg::OFS_NEAR_TOUCH;
	wire        wr_ndft = reg_wr &&
	                      reg_addr == tkcda_pkg::OFS_NEAR_DRIFT;

	// Touch comparison and drift detection, purely combinational so the
	// flags follow the measurement with no buffering
	genvar g;
	generate
		for (g = 0; g < tkcda_pkg::NCH; g++) begin : g_cmp
			assign diff_w[g] = (raw_r[g] > cal_r[g]) ?
			                   raw_r[g] - cal_r[g] : cal_r[g] - raw_r[g];
			assign touch_w[g] = {4'h0, diff_w[g]} > {8'h00, tthr_r[g]};
			assign drift_w[g] = {4'h0, diff_w[g]} < {8'h00, ethr_r[g]};
		end
	endgenerate

	// Key filter: keep the mode-count largest changes among group members;
	// channels outside the group pass through unfiltered
	// Rank saturates at three, all that the widest mode needs
	logic [15:0] filt_nxt;
	always_comb begin
		logic [1:0]    lim;
		logic [1:0]    rank;
		lim = kf_ctrl_r[tkcda_pkg::KF_MODE_LSB +: 2];
		rank = 2'd0;
		filt_nxt = touch_w & ~kf_mask_r;
		for (int i = 0; i < tkcda_pkg::NCH; i++) begin
			rank = 2'd0;
			for (int j = 0; j < tkcda_pkg::NCH; j++) begin
				if (j != i && touch_w[j] && kf_mask_r[j] &&
				    (diff_w[j] > diff_w[i] ||
				     (diff_w[j] == diff_w[i] && j < i)) && rank != 2'd3)
					rank = rank + 2'd1;
			end
			if (touch_w[i] && kf_mask_r[i] &&
			    (lim == 2'd0 || rank < lim))
				filt_nxt[i] = 1'b1;
		end
	end

	// Host registers
	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			dtype_r      <= tkcda_pkg::RST_BYTE;
			kf_ctrl_r    <= tkcda_pkg::RST_BYTE;
			kf_mask_r    <= tkcda_pkg::RST_WORD;
			near_cfg_r   <= tkcda_pkg::RST_BYTE;
			near_touch_r <= tkcda_pkg::RST_BYTE;
			near_drift_r <= tkcda_pkg::RST_BYTE;
		end else if (reg_wr) begin
			if (wr_dt)
				dtype_r <= reg_wdata;
			if (wr_kfc)
				kf_ctrl_r <= reg_wdata;
			if (wr_mlo)
				kf_mask_r[7:0] <= reg_wdata;
			if (wr_mhi)
				kf_mask_r[15:8] <= reg_wdata;
			if (wr_ncfg)
				near_cfg_r <= reg_wdata;
			if (wr_ntch)
				near_touch_r <= reg_wdata;
			if (wr_ndft)
				near_drift_r <= reg_wdata;
		end
	end

	// Status flags and nearness results
	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			press_r    <= tkcda_pkg::RST_WORD;
			filt_r     <= tkcda_pkg::RST_WORD;
			near_res_r <= tkcda_pkg::RST_WORD;
		end else begin
			press_r    <= touch_w;
			filt_r     <= filt_nxt;
			near_res_r <= near_result;
		end
	end

	// Frozen set: capture starts when the type is chosen, ends when
	// every channel has delivered one sample
	wire frz_start = wr_dt && reg_wdata == tkcda_pkg::DT_FROZEN;
	wire [15:0] got_next = frozen_got_r | (16'h0001 << meas_ch);
	wire        got_all  = got_next == 16'hffff;
	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			frozen_busy_r <= 1'b0;
			frozen_got_r  <= tkcda_pkg::RST_WORD;
		end else if (frz_start) begin
			frozen_busy_r <= 1'b1;
			frozen_got_r  <= tkcda_pkg::RST_WORD;
		end else if (frozen_busy_r && meas_valid) begin
			frozen_got_r <= got_next;
			if (got_all)
				frozen_busy_r <= 1'b0;
		end
	end

	// Per-channel storage
	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			for (int k = 0; k < tkcda_pkg::NCH; k++) begin
				raw_r[k]  <= '0;
				cal_r[k]  <= '0;
				frz_r[k]  <= '0;
			end
		end else begin
			if (meas_valid) begin
				raw_r[meas_ch] <= meas_imp;
				if (frozen_busy_r && frz_sel && !frozen_got_r[meas_ch])
					frz_r[meas_ch] <= meas_imp;
			end
			// Drift tracked one step at a time at each calibration point so a
			// slow hand approach is not absorbed as quickly as noise
			if (cal_tick) begin
				for (int k = 0; k < tkcda_pkg::NCH; k++) begin
					if (drift_w[k] && raw_r[k] > cal_r[k])
						cal_r[k] <= cal_r[k] + 13'd1;
					else if (drift_w[k] && raw_r[k] < cal_r[k])
						cal_r[k] <= cal_r[k] - 13'd1;
				end
			end
		end
	end

	// Per-channel host settings; the delay high byte has no bits behind
	// it, so writes there are dropped
	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			for (int k = 0; k < tkcda_pkg::NCH; k++) begin
				tthr_r[k] <= '0;
				ethr_r[k] <= '0;
				dly_r[k]  <= '0;
			end
		end else begin
			if (wr_tthr) begin
				if (ch_hi)
					tthr_r[ch_idx][8] <= reg_wdata[0];
				else
					tthr_r[ch_idx][7:0] <= reg_wdata;
			end
			if (wr_ethr) begin
				if (ch_hi)
					ethr_r[ch_idx][8] <= reg_wdata[0];
				else
					ethr_r[ch_idx][7:0] <= reg_wdata;
			end
			if (wr_dly)
				dly_r[ch_idx] <= reg_wdata[5:0];
		end
	end

	// Channel slot contents, chosen by the selector at read time
	logic [15:0] slot_w;
	always_comb begin
		case (dtype_r)
			tkcda_pkg::DT_TOUCH_THR: slot_w = {7'h00, tthr_r[ch_idx]};
			tkcda_pkg::DT_ENV_THR:   slot_w = {7'h00, ethr_r[ch_idx]};
			tkcda_pkg::DT_DELAY:     slot_w = {10'h000, dly_r[ch_idx]};
			tkcda_pkg::DT_RAW:       slot_w = {3'h0, raw_r[ch_idx]};
			tkcda_pkg::DT_CAL:       slot_w = {3'h0, cal_r[ch_idx]};
			tkcda_pkg::DT_FROZEN:    slot_w = {3'h0, frz_r[ch_idx]};
			default:                 slot_w = 16'h0000;
		endcase
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		reg_rdata = 8'h00;
		if (in_ch)
			reg_rdata = ch_hi ? slot_w[15:8] : slot_w[7:0];
		else begin
			case (reg_addr)
				tkcda_pkg::OFS_DATA_TYPE:  reg_rdata = dtype_r;
				tkcda_pkg::OFS_KF_CTRL:    reg_rdata = kf_ctrl_r;
				tkcda_pkg::OFS_KF_MASK_LO: reg_rdata = kf_mask_r[7:0];
				tkcda_pkg::OFS_KF_MASK_HI: reg_rdata = kf_mask_r[15:8];
				tkcda_pkg::OFS_NEAR_CFG:   reg_rdata = near_cfg_r;
				tkcda_pkg::OFS_NEAR_TOUCH: reg_rdata = near_touch_r;
				tkcda_pkg::OFS_NEAR_DRIFT: reg_rdata = near_drift_r;
				tkcda_pkg::OFS_FILT_LO:    reg_rdata = filt_r[7:0];
				tkcda_pkg::OFS_FILT_HI:    reg_rdata = filt_r[15:8];
				tkcda_pkg::OFS_NEAR_RES0:  reg_rdata = near_res_r[7:0];
				tkcda_pkg::OFS_NEAR_RES1:  reg_rdata = near_res_r[15:8];
				tkcda_pkg::OFS_PRESS_LO:   reg_rdata = press_r[7:0];
				tkcda_pkg::OFS_PRESS_HI:   reg_rdata = press_r[15:8];
				default:                   reg_rdata = 8'h00;
			endcase
		end
	end

	// Controls to the nearness engine and the analog delay line
	assign near_enable    = kf_ctrl_r[tkcda_pkg::NEAR_EN_BIT];
	assign near_channel   = kf_ctrl_r[tkcda_pkg::NEAR_CH_LSB +: 4];
	assign near_dither    = near_cfg_r[tkcda_pkg::DITH_LSB +: 2];
	assign chan_delay_sel = dly_r[meas_ch];
endmodule // tkcda_top
